// ### rtl/tec_pkg.sv
// How it works
// - Interrupt pulse on overflow or underflow
// - Count value readable at any time
// - Stopped write loads reload and counter
// - Running write loads reload register only
// - Normal: secondary high, primary edges count
// - X4: primary rise, secondary high counts up
// - X4: primary fall, secondary high counts down
// - X4 on units three, four; three selects
// - Normal fixed on unit two
// - Count only while start flag set
// - Wrap reloads from reload register
// - Free-run wraps without reload
package tec_pkg;

    // =====================================================================
    // Widths and values
    localparam int TEC_CNT_W = 16;
    localparam logic [TEC_CNT_W-1:0] TEC_COUNT_RST = 16'h0000;
    localparam logic [TEC_CNT_W-1:0] TEC_RELOAD_RST = 16'h0000;
    localparam logic [TEC_CNT_W-1:0] TEC_COUNT_MAX = 16'hFFFF;
    localparam logic [TEC_CNT_W-1:0] TEC_COUNT_MIN = 16'h0000;
    localparam logic [TEC_CNT_W-1:0] TEC_COUNT_ONE = 16'h0001;
    localparam int TEC_UNIT_TWO = 2;
    localparam int TEC_UNIT_THREE = 3;
    localparam int TEC_UNIT_FOUR = 4;

    // =====================================================================
    // Types
    typedef struct packed {
        logic primary;
        logic secondary;
    } tec_phase_t;

    typedef struct packed {
        logic inc;
        logic dec;
    } tec_step_t;

    typedef enum logic [0:0] {
        TEC_DEC_NORMAL = 1'b0,
        TEC_DEC_X4 = 1'b1
    } tec_decode_t;

endpackage

// ### rtl/tec_phase_sync.sv
`timescale 1ns/1ps
module tec_phase_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tec_pkg::tec_phase_t phase_raw,
    output tec_pkg::tec_phase_t phase_now,
    output tec_pkg::tec_phase_t phase_prev
);
    import tec_pkg::*;

    tec_phase_t meta_q, meta_d;
    tec_phase_t sync_q, sync_d;
    tec_phase_t prev_q, prev_d;

    // =====================================================================
    // Two-stage synchroniser plus previous sample
    always_comb begin
        meta_d = phase_raw;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign phase_now = sync_q;
    assign phase_prev = prev_q;

    a_prev_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 phase_prev == $past(phase_now))
        else $error("previous sample does not trail current sample");

endmodule // tec_phase_sync

// ### rtl/tec_event_counter.sv
`timescale 1ns/1ps
module tec_event_counter #(
    parameter int UNIT_INDEX = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic phase_primary_in,
    input wire logic phase_secondary_in,
    input wire logic count_start,
    input wire logic free_run,
    input wire logic x4_select,
    input wire logic wr_en,
    input wire logic [tec_pkg::TEC_CNT_W-1:0] wr_data,
    output logic [tec_pkg::TEC_CNT_W-1:0] count_value,
    output logic [tec_pkg::TEC_CNT_W-1:0] reload_value,
    output logic irq
);
    import tec_pkg::*;

    tec_phase_t phase_raw;
    tec_phase_t phase_now;
    tec_phase_t phase_prev;
    tec_decode_t decode_mode;
    tec_step_t step;
    logic [TEC_CNT_W-1:0] count_q, count_d;
    logic [TEC_CNT_W-1:0] reload_q, reload_d;
    logic irq_q, irq_d;
    logic at_wrap;

    // =====================================================================
    // Quadrature position of a phase pair, in gray order
    function automatic logic [1:0] quad_pos(input tec_phase_t ph);
        unique case ({ph.primary, ph.secondary})
            2'b00: quad_pos = 2'h0;
            2'b01: quad_pos = 2'h1;
            2'b11: quad_pos = 2'h2;
            2'b10: quad_pos = 2'h3;
        endcase
    endfunction

    // =====================================================================
    // Input capture
    // Pins are asynchronous; the sync module adds two flops before decode
    assign phase_raw = '{primary: phase_primary_in, secondary: phase_secondary_in};

    tec_phase_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .phase_raw(phase_raw),
        .phase_now(phase_now),
        .phase_prev(phase_prev)
    );

    // =====================================================================
    // Decode selection, fixed on units two and four, selectable on any other unit
    generate
        if (UNIT_INDEX == TEC_UNIT_TWO) begin : g_fixed_normal
            assign decode_mode = TEC_DEC_NORMAL;
        end else if (UNIT_INDEX == TEC_UNIT_FOUR) begin : g_fixed_x4
            assign decode_mode = TEC_DEC_X4;
        end else begin : g_selectable
            assign decode_mode = x4_select ? TEC_DEC_X4 : TEC_DEC_NORMAL;
        end
    endgenerate

    // =====================================================================
    // Step decode
    always_comb begin
        logic [1:0] pos_delta;
        pos_delta = 2'(quad_pos(phase_now) - quad_pos(phase_prev));
        step = '0;
        unique case (decode_mode)
            TEC_DEC_NORMAL: begin
                // Gated by the current synced secondary level, not the previous one
                if (phase_now.secondary) begin
                    step.inc = phase_now.primary & ~phase_prev.primary;
                    step.dec = ~phase_now.primary & phase_prev.primary;
                end
            end
            TEC_DEC_X4: begin
                // Both phases moving at once is illegal; no step taken
                step.inc = (pos_delta == 2'h1);
                step.dec = (pos_delta == 2'h3);
            end
        endcase
    end

    // =====================================================================
    // Counter, reload register, interrupt pulse
    // Judged on the pre-step value, so irq and reload land in one cycle
    assign at_wrap = (step.inc && count_q == TEC_COUNT_MAX) ||
                     (step.dec && count_q == TEC_COUNT_MIN);

    always_comb begin
        count_d = count_q;
        reload_d = reload_q;
        irq_d = 1'b0;
        // Stopped write wins over a step; no step is taken then anyway
        if (wr_en) begin
            reload_d = wr_data;
            if (!count_start) begin
                count_d = wr_data;
            end
        end
        if (count_start && (step.inc || step.dec)) begin
            if (at_wrap) begin
                irq_d = 1'b1;
            end
            if (at_wrap && !free_run) begin
                // A write in the same cycle is taken as the new reload value
                count_d = reload_d;
            end else if (step.inc) begin
                count_d = TEC_CNT_W'(count_q + TEC_COUNT_ONE);
            end else begin
                count_d = TEC_CNT_W'(count_q - TEC_COUNT_ONE);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_q <= TEC_COUNT_RST;
            reload_q <= TEC_RELOAD_RST;
            irq_q <= 1'b0;
        end else begin
            count_q <= count_d;
            reload_q <= reload_d;
            irq_q <= irq_d;
        end
    end

    assign count_value = count_q;
    assign reload_value = reload_q;
    assign irq = irq_q;

    // =====================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_up_at_max;
        count_start && step.inc && count_q == TEC_COUNT_MAX;
    endsequence

    sequence s_down_at_min;
        count_start && step.dec && count_q == TEC_COUNT_MIN;
    endsequence

    sequence s_sec_high_primary_rise;
        phase_now.secondary && !phase_now.primary ##1
        phase_now.secondary && phase_now.primary;
    endsequence

    sequence s_sec_high_primary_fall;
        phase_now.secondary && phase_now.primary ##1
        phase_now.secondary && !phase_now.primary;
    endsequence

    a_irq_on_wrap: assert property ((s_up_at_max or s_down_at_min) |=> irq)
        else $error("wrap did not raise interrupt");

    a_irq_has_cause: assert property (irq |-> $past(count_start) &&
        (($past(step.inc) && $past(count_q) == TEC_COUNT_MAX) ||
         ($past(step.dec) && $past(count_q) == TEC_COUNT_MIN)))
        else $error("interrupt without wrap");

    a_reload_on_wrap: assert property ((s_up_at_max or s_down_at_min) ##0
        (!free_run && !wr_en) |=> count_value == $past(reload_q))
        else $error("wrap did not reload counter");

    a_free_run_wrap: assert property (s_up_at_max ##0 free_run |=>
        count_value == TEC_COUNT_MIN)
        else $error("free run did not wrap to zero");

    a_stopped_write: assert property (wr_en && !count_start |=>
        count_value == $past(wr_data) && reload_value == $past(wr_data))
        else $error("stopped write not loaded into both");

    a_running_write: assert property (wr_en && count_start && !step.inc &&
        !step.dec |=> count_value == $past(count_q) && reload_value == $past(wr_data))
        else $error("running write touched counter");

    a_hold_stopped: assert property (!count_start && !wr_en |=> $stable(count_value))
        else $error("counter moved while stopped");

    a_normal_rise_up: assert property (decode_mode == TEC_DEC_NORMAL && count_start &&
        !wr_en && step.inc && count_q != TEC_COUNT_MAX |=>
        count_value == TEC_CNT_W'($past(count_q) + TEC_COUNT_ONE))
        else $error("normal rising edge did not count up");

    a_normal_no_step: assert property (decode_mode == TEC_DEC_NORMAL &&
        !phase_now.secondary |-> !step.inc && !step.dec)
        else $error("normal decode stepped with secondary low");

    a_x4_up_dir: assert property (decode_mode == TEC_DEC_X4 ##0
        s_sec_high_primary_rise |-> step.inc && !step.dec)
        else $error("quadrature rise did not step up");

    a_x4_down_dir: assert property (decode_mode == TEC_DEC_X4 ##0
        s_sec_high_primary_fall |-> step.dec && !step.inc)
        else $error("quadrature fall did not step down");

    a_normal_fall_down: assert property (decode_mode == TEC_DEC_NORMAL && count_start &&
        !wr_en && step.dec && count_q != TEC_COUNT_MIN |=>
        count_value == TEC_CNT_W'($past(count_q) - TEC_COUNT_ONE))
        else $error("normal falling edge did not count down");

    a_x4_up_count: assert property (decode_mode == TEC_DEC_X4 && count_start &&
        !wr_en && step.inc && count_q != TEC_COUNT_MAX |=>
        count_value == TEC_CNT_W'($past(count_q) + TEC_COUNT_ONE))
        else $error("quadrature step did not count up");

    a_x4_down_count: assert property (decode_mode == TEC_DEC_X4 && count_start &&
        !wr_en && step.dec && count_q != TEC_COUNT_MIN |=>
        count_value == TEC_CNT_W'($past(count_q) - TEC_COUNT_ONE))
        else $error("quadrature step did not count down");

    a_free_run_under: assert property (s_down_at_min ##0 free_run |=>
        count_value == TEC_COUNT_MAX)
        else $error("free run did not wrap to all ones");

endmodule // tec_event_counter

// ### dv/tec_pulse_source.sv
`timescale 1ns/1ps
// ==========================================
// Two-phase pulse source, one quarter step per request
module tec_pulse_source (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic step_req,
    input wire logic step_up,
    output tec_pkg::tec_phase_t phase
);
    import tec_pkg::*;
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    always_comb begin
        idx_d = idx_q;
        if (step_req) begin
            idx_d = step_up ? idx_q + 2'h1 : idx_q - 2'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idx_q <= 2'h3;
        end else begin
            idx_q <= idx_d;
        end
    end
    // Gray order (p,s) 01,11,10,00: only one pin moves per step
    assign phase = '{primary: idx_q[0] ^ idx_q[1], secondary: ~idx_q[1]};
endmodule // tec_pulse_source

// ### dv/two_phase_event_counter_test.sv
`timescale 1ns/1ps
module two_phase_event_counter_test;
    import tec_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic count_start = 1'b0;
    logic free_run = 1'b0;
    logic x4_select = 1'b1;
    logic wr_en = 1'b0;
    logic [TEC_CNT_W-1:0] wr_data = 16'h0000;
    logic step_req = 1'b0;
    logic step_up = 1'b1;
    tec_phase_t phase;
    logic [TEC_CNT_W-1:0] count_value;
    logic [TEC_CNT_W-1:0] reload_value;
    logic irq;
    logic [TEC_CNT_W-1:0] count_two;
    logic [TEC_CNT_W-1:0] count_four;
    int failures = 0;
    int checks_done = 0;
    int irq_seen = 0;
    int cycles = 0;

    // ==========================================
    // Clock, source model and counter
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    tec_pulse_source src (.sys_clk(sys_clk), .rst_n(rst_n), .step_req(step_req),
        .step_up(step_up), .phase(phase));
    tec_event_counter #(.UNIT_INDEX(TEC_UNIT_THREE)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .phase_primary_in(phase.primary), .phase_secondary_in(phase.secondary),
        .count_start(count_start), .free_run(free_run), .x4_select(x4_select),
        .wr_en(wr_en), .wr_data(wr_data), .count_value(count_value),
        .reload_value(reload_value), .irq(irq));
    // Fixed-decode units share all inputs, so x4_select must not move them
    tec_event_counter #(.UNIT_INDEX(TEC_UNIT_TWO)) dut_two (.sys_clk(sys_clk), .rst_n(rst_n),
        .phase_primary_in(phase.primary), .phase_secondary_in(phase.secondary),
        .count_start(count_start), .free_run(free_run), .x4_select(x4_select),
        .wr_en(wr_en), .wr_data(wr_data), .count_value(count_two),
        .reload_value(), .irq());
    tec_event_counter #(.UNIT_INDEX(TEC_UNIT_FOUR)) dut_four (.sys_clk(sys_clk), .rst_n(rst_n),
        .phase_primary_in(phase.primary), .phase_secondary_in(phase.secondary),
        .count_start(count_start), .free_run(free_run), .x4_select(x4_select),
        .wr_en(wr_en), .wr_data(wr_data), .count_value(count_four),
        .reload_value(), .irq());
    always @(posedge sys_clk) begin
        if (irq === 1'b1) begin
            irq_seen++;
        end
        cycles++;
        // Whole run needs well under 1000 cycles
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    // ==========================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [TEC_CNT_W-1:0] got, input logic [TEC_CNT_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [TEC_CNT_W-1:0] d);
        wr_en = 1'b1;
        wr_data = d;
        tick(1);
        wr_en = 1'b0;
        tick(1);
    endtask
    // Eight cycles per level keeps every edge visible to the sampler
    task automatic step(input logic up, input int n);
        repeat (n) begin
            step_up = up;
            step_req = 1'b1;
            tick(1);
            step_req = 1'b0;
            tick(7);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_stopped();
        wr(16'h1234);
        chk(count_value, 16'h1234);
        chk(reload_value, 16'h1234);
        step(1'b1, 3);
        chk(count_value, 16'h1234);
    endtask
    task automatic t_x4_up_wrap();
        wr(16'hFFFD);
        count_start = 1'b1;
        wr(16'h0100);
        chk(count_value, 16'hFFFD);
        chk(reload_value, 16'h0100);
        step(1'b1, 2);
        chk(count_value, 16'hFFFF);
        step(1'b1, 1);
        chk(count_value, 16'h0100);
        chk(16'(irq_seen), 16'h0001);
        chk(count_two, 16'hFFFE);
        count_start = 1'b0;
    endtask
    task automatic t_x4_down_wrap();
        wr(16'h0001);
        count_start = 1'b1;
        step(1'b0, 2);
        chk(count_value, 16'h0001);
        chk(16'(irq_seen), 16'h0002);
        free_run = 1'b1;
        step(1'b0, 2);
        chk(count_value, 16'hFFFF);
        chk(16'(irq_seen), 16'h0003);
        step(1'b1, 1);
        chk(count_value, 16'h0000);
        chk(16'(irq_seen), 16'h0004);
        free_run = 1'b0;
        count_start = 1'b0;
    endtask
    task automatic t_normal();
        x4_select = 1'b0;
        wr(16'h0005);
        count_start = 1'b1;
        step(1'b1, 4);
        chk(count_value, 16'h0006);
        chk(count_two, 16'h0006);
        chk(count_four, 16'h0009);
        step(1'b0, 4);
        chk(count_value, 16'h0005);
        chk(count_four, 16'h0005);
        count_start = 1'b0;
    endtask

    initial begin
        tick(12);
        chk(count_value, TEC_COUNT_RST);
        chk(reload_value, TEC_RELOAD_RST);
        rst_n = 1'b1;
        tick(2);
        t_stopped();
        t_x4_up_wrap();
        t_x4_down_wrap();
        t_normal();
        report_and_stop();
    end
endmodule // two_phase_event_counter_test
